// *** include/qdac_cfg.svh ***
// Purpose: offsets, field positions, reset values for the quad converter register link
// Assumes: one aligned 32-bit word per host register
// Notes: included by bare name
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
// ==========================================================
// command word fields
`define QDAC_DATA_W 16
`define QDAC_CODE_MSB 15
`define QDAC_CODE_LSB 2
`define QDAC_RANGE_MSB 1
`define QDAC_TRIM_MSB 5
`define QDAC_CHAN_ALL 3'h4
`define QDAC_FN_IO_ADDR 3'h1
// ==========================================================
// function word bit positions
`define QDAC_FN_LGO_BIT 5
`define QDAC_FN_D1_DIR_BIT 4
`define QDAC_FN_D1_VAL_BIT 3
`define QDAC_FN_D0_DIR_BIT 2
`define QDAC_FN_D0_VAL_BIT 1
// ==========================================================
// reset values
`define QDAC_CODE_RST 14'h0000
`define QDAC_RANGE_RST 2'h0
`define QDAC_TRIM_RST 6'h00
// ==========================================================
// host register map (byte offsets)
`define QDAC_OFS_CMD 12'h000
`define QDAC_OFS_STATUS 12'h004
`define QDAC_CMD_DATA_LSB 0
`define QDAC_CMD_CHAN_LSB 16
`define QDAC_CMD_REG_LSB 19
`define QDAC_ST_DETECT_BIT 16
`endif

// *** include/qdac_pkg.sv ***
// Purpose: shared types of the quad converter register link
// Assumes: nothing
// Notes: numbers live in qdac_cfg.svh
package qdac_pkg;
  typedef logic [13:0] code_t;
  typedef logic [1:0] range_t;
  typedef logic signed [5:0] trim_t;
  typedef logic signed [6:0] adj_t;
  typedef logic [2:0] sel_t;
  typedef enum logic [2:0] {
    REG_FUNCTION = 3'h0,
    REG_CODE = 3'h2,
    REG_RANGE = 3'h3,
    REG_TRIM = 3'h4
  } reg_sel_e;
  typedef enum logic [1:0] {
    SPAN_10V = 2'h0,
    SPAN_10V2564 = 2'h1,
    SPAN_10V5263 = 2'h2,
    SPAN_BAD = 2'h3
  } span_e;
endpackage

// *** include/qdac_link_if.sv ***
// Purpose: decoded command link between host controller and converter logic
// Assumes: both ends on pclk
// Notes: one command per cmd_valid pulse, always accepted
`timescale 1ns/1ps
`default_nettype none
interface qdac_link_if;
  logic cmd_valid;
  logic [2:0] register_select_field;
  logic [2:0] channel_select_field;
  logic [15:0] cmd_data;
  logic [15:0] fn_readback;
  logic supply_detect;
  modport dev (
    input cmd_valid, register_select_field, channel_select_field, cmd_data,
    output fn_readback, supply_detect
  );
  modport host (
    output cmd_valid, register_select_field, channel_select_field, cmd_data,
    input fn_readback, supply_detect
  );
endinterface
`default_nettype wire

// *** src/qdac_device.sv ***
// Overview of operation
// R1 - register select 010 writes output code
// R2 - channel codes 0-3 one channel, 4 all
// R3 - code from data 15..2, bits 1..0 ignored
// R4 - register select 011 writes range, bits 1..0
// R5 - per-channel range: 00, 01, 10 spans
// R6 - register select 100 writes trim, bits 5..0
// R7 - trim is two's complement quarter steps
// R8 - trim moves both endpoints by half step
// R9 - clamp until supplies stable and code written
// R10 - low fault input clamps and disconnects outputs
// R11 - supply detector state on its own pin
// R12 - two general-purpose pins, host controlled
// R13 - direction bit set means output, default input
// R14 - input pin readback shows pin, writes ignored
// R15 - ground offset correction only while enabled
// R16 - broadcast write updates only the chosen register
//
// Purpose: converter-side register decode, output control and i/o port
// Assumes: commands arrive already deframed on the link, one per pulse
// Notes: analog parts are represented by gate and setting outputs
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"
module qdac_device #(
  parameter int NCH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  qdac_link_if.dev link,
  input wire logic supply_stable,
  input wire logic supply_fault_input_n,
  input wire logic gp_pin_zero_in,
  input wire logic gp_pin_one_in,
  output logic gp_pin_zero_out,
  output logic gp_pin_zero_oe,
  output logic gp_pin_one_out,
  output logic gp_pin_one_oe,
  output qdac_pkg::code_t [NCH-1:0] channel_output_code,
  output qdac_pkg::range_t [NCH-1:0] channel_range_select,
  output qdac_pkg::trim_t [NCH-1:0] channel_gain_trim,
  output qdac_pkg::span_e [NCH-1:0] channel_span,
  output qdac_pkg::adj_t [NCH-1:0] pos_endpoint_adj,
  output qdac_pkg::adj_t [NCH-1:0] neg_endpoint_adj,
  output logic [NCH-1:0] amp_connect_gate,
  output logic [NCH-1:0] output_clamp_gate,
  output logic local_gnd_adjust_en,
  output logic supply_detect_output
);
  import qdac_pkg::*;

  // ==========================================================
  // input synchronisers
  // all four pin levels are asynchronous to pclk
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic supply_ok;
  logic gp0_s;
  logic gp1_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {gp_pin_one_in, gp_pin_zero_in, supply_fault_input_n, supply_stable};
      pin_sync_r <= pin_meta_r;
    end
  end

  // fault input low overrides the internal detector
  assign supply_ok = pin_sync_r[0] & pin_sync_r[1]; // [R10]
  assign gp0_s = pin_sync_r[2];
  assign gp1_s = pin_sync_r[3];

  // ==========================================================
  // command decode
  logic [NCH-1:0] hit;
  logic wr_code;
  logic wr_range;
  logic wr_trim;
  logic wr_io;

  always_comb begin
    hit = '0;
    if (link.channel_select_field == `QDAC_CHAN_ALL) begin
      hit = '1; // [R2] [R16]
    end else if (link.channel_select_field < 3'(NCH)) begin
      hit[link.channel_select_field[1:0]] = 1'b1; // [R2]
    end
  end

  assign wr_code = link.cmd_valid && (link.register_select_field == REG_CODE); // [R1]
  assign wr_range = link.cmd_valid && (link.register_select_field == REG_RANGE); // [R4]
  assign wr_trim = link.cmd_valid && (link.register_select_field == REG_TRIM); // [R6]
  assign wr_io = link.cmd_valid && (link.register_select_field == REG_FUNCTION)
    && (link.channel_select_field == `QDAC_FN_IO_ADDR);

  // ==========================================================
  // per-channel settings
  // only the register named by the command changes, even on broadcast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_output_code <= {NCH{`QDAC_CODE_RST}};
      channel_range_select <= {NCH{`QDAC_RANGE_RST}};
      channel_gain_trim <= {NCH{`QDAC_TRIM_RST}};
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_code && hit[i]) begin
          channel_output_code[i] <= link.cmd_data[`QDAC_CODE_MSB:`QDAC_CODE_LSB]; // [R1] [R3] [R16]
        end
        if (wr_range && hit[i]) begin
          channel_range_select[i] <= link.cmd_data[`QDAC_RANGE_MSB:0]; // [R4] [R5] [R16]
        end
        if (wr_trim && hit[i]) begin
          channel_gain_trim[i] <= link.cmd_data[`QDAC_TRIM_MSB:0]; // [R6] [R16]
        end
      end
    end
  end

  // ==========================================================
  // span decode and endpoint trim
  // endpoints are in eighth-lsb units: a quarter step split in half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_span <= {NCH{SPAN_10V}};
      pos_endpoint_adj <= '0;
      neg_endpoint_adj <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        unique case (channel_range_select[i])
          2'h0: channel_span[i] <= SPAN_10V; // [R5]
          2'h1: channel_span[i] <= SPAN_10V2564; // [R5]
          2'h2: channel_span[i] <= SPAN_10V5263; // [R5]
          2'h3: channel_span[i] <= SPAN_BAD;
        endcase
        // sign extension keeps -8..+7.75 intact; zero means untouched
        pos_endpoint_adj[i] <= adj_t'(channel_gain_trim[i]); // [R7] [R8]
        neg_endpoint_adj[i] <= -adj_t'(channel_gain_trim[i]); // [R7] [R8]
      end
    end
  end

  // ==========================================================
  // output clamp control
  // a brownout forgets earlier writes, so a fresh code is needed after it
  logic [NCH-1:0] code_valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_valid_r <= '0;
    end else if (!supply_ok) begin
      code_valid_r <= '0; // [R9] [R10]
    end else begin
      code_valid_r <= code_valid_r | (wr_code ? hit : '0); // [R9]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_connect_gate <= '0;
      output_clamp_gate <= '1;
    end else begin
      // gating on supply_ok here too lets a fault clamp without waiting a cycle
      amp_connect_gate <= supply_ok ? code_valid_r : '0; // [R9] [R10]
      output_clamp_gate <= supply_ok ? ~code_valid_r : '1; // [R9] [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_detect_output <= 1'b0;
    end else begin
      supply_detect_output <= pin_sync_r[0]; // [R11]
    end
  end

  // ==========================================================
  // general-purpose port and ground correction enable
  logic d0_dir_r;
  logic d1_dir_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d0_dir_r <= 1'b0;
      d1_dir_r <= 1'b0;
      gp_pin_zero_out <= 1'b0;
      gp_pin_one_out <= 1'b0;
      local_gnd_adjust_en <= 1'b0;
    end else if (wr_io) begin
      local_gnd_adjust_en <= link.cmd_data[`QDAC_FN_LGO_BIT]; // [R15]
      d0_dir_r <= link.cmd_data[`QDAC_FN_D0_DIR_BIT]; // [R12] [R13]
      d1_dir_r <= link.cmd_data[`QDAC_FN_D1_DIR_BIT]; // [R12] [R13]
      // value bits only count when the same word makes the pin an output
      if (link.cmd_data[`QDAC_FN_D0_DIR_BIT]) begin
        gp_pin_zero_out <= link.cmd_data[`QDAC_FN_D0_VAL_BIT]; // [R12] [R14]
      end
      if (link.cmd_data[`QDAC_FN_D1_DIR_BIT]) begin
        gp_pin_one_out <= link.cmd_data[`QDAC_FN_D1_VAL_BIT]; // [R12] [R14]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_pin_zero_oe <= 1'b0;
      gp_pin_one_oe <= 1'b0;
    end else begin
      gp_pin_zero_oe <= d0_dir_r; // [R13]
      gp_pin_one_oe <= d1_dir_r; // [R13]
    end
  end

  // ==========================================================
  // readback toward the host
  logic [15:0] fn_rb_r;
  logic detect_rb_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fn_rb_r <= 16'h0000;
      detect_rb_r <= 1'b0;
    end else begin
      fn_rb_r <= 16'h0000;
      fn_rb_r[`QDAC_FN_LGO_BIT] <= local_gnd_adjust_en;
      fn_rb_r[`QDAC_FN_D1_DIR_BIT] <= d1_dir_r;
      fn_rb_r[`QDAC_FN_D0_DIR_BIT] <= d0_dir_r;
      fn_rb_r[`QDAC_FN_D1_VAL_BIT] <= d1_dir_r ? gp_pin_one_out : gp1_s; // [R14]
      fn_rb_r[`QDAC_FN_D0_VAL_BIT] <= d0_dir_r ? gp_pin_zero_out : gp0_s; // [R14]
      detect_rb_r <= pin_sync_r[0]; // [R11]
    end
  end

  assign link.fn_readback = fn_rb_r;
  assign link.supply_detect = detect_rb_r;
endmodule
`default_nettype wire

// *** src/qdac_host.sv ***
// Purpose: host controller; apb registers turned into link commands
// Assumes: software formats register select, channel and data itself
// Notes: no waits, pready is always high in the access phase
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"
module qdac_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  qdac_link_if.host link
);
  import qdac_pkg::*;

  // ==========================================================
  // apb decode
  logic setup;
  logic hit_cmd;
  logic hit_status;

  assign setup = psel && !penable;
  assign hit_cmd = (paddr == `QDAC_OFS_CMD);
  assign hit_status = (paddr == `QDAC_OFS_STATUS);

  // answer prepared in setup so the access phase is a single cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !(hit_cmd || hit_status);
      prdata <= 32'h0000_0000;
      if (setup && !pwrite && hit_status) begin
        prdata[15:0] <= link.fn_readback;
        prdata[`QDAC_ST_DETECT_BIT] <= link.supply_detect;
      end
    end
  end

  // ==========================================================
  // command issue
  // write of the command word takes effect at the access edge
  logic cmd_valid_r;
  logic [2:0] reg_r;
  logic [2:0] chan_r;
  logic [15:0] data_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid_r <= 1'b0;
      reg_r <= 3'h0;
      chan_r <= 3'h0;
      data_r <= 16'h0000;
    end else begin
      cmd_valid_r <= psel && penable && pready && pwrite && hit_cmd; // [R1] [R4] [R6]
      if (psel && penable && pready && pwrite && hit_cmd) begin
        reg_r <= pwdata[`QDAC_CMD_REG_LSB +: 3];
        chan_r <= pwdata[`QDAC_CMD_CHAN_LSB +: 3];
        data_r <= pwdata[`QDAC_CMD_DATA_LSB +: 16]; // [R3]
      end
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.register_select_field = reg_r;
  assign link.channel_select_field = chan_r;
  assign link.cmd_data = data_r;
endmodule
`default_nettype wire

// *** test/qdac_monitor.sv ***
// Purpose: checks on the link between host controller and converter logic
// Assumes: single clock pclk, async active-low presetn
// Notes: sees only the link signals, instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module qdac_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic [2:0] register_select_field,
  input wire logic [2:0] channel_select_field,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] fn_readback,
  input wire logic supply_detect
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // helpers
  logic fn_cmd;
  assign fn_cmd = cmd_valid && register_select_field == 3'h0 && channel_select_field == 3'h1;
  // ==========================================================
  // assertions
  a_cmd_one_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_fields_held: assert property (!cmd_valid |-> $stable(cmd_data) &&
    $stable(register_select_field) && $stable(channel_select_field))
    else $error("command fields moved without a strobe");
  // readback trails a command by two edges: settings register, then readback register
  a_gnd_adj_write: assert property (fn_cmd |-> ##2 fn_readback[5] == $past(cmd_data[5], 2))
    else $error("ground adjust enable not taken from function word");
  a_dir_bits_write: assert property (fn_cmd |-> ##2
    fn_readback[4] == $past(cmd_data[4], 2) && fn_readback[2] == $past(cmd_data[2], 2))
    else $error("pin direction not taken from function word");
  a_out_value_write: assert property (fn_cmd && cmd_data[4] |-> ##2
    fn_readback[3] == $past(cmd_data[3], 2))
    else $error("output pin value not taken from function word");
  a_setup_kept: assert property (!fn_cmd |-> ##2
    $stable(fn_readback[5:4]) && $stable(fn_readback[2]))
    else $error("function settings moved without a function command");
  a_out_value_kept: assert property (!fn_cmd ##2 fn_readback[4] |->
    $stable(fn_readback[3]))
    else $error("output pin value moved without a command");
  a_spare_bits_zero: assert property (fn_readback[15:6] == 10'h000 &&
    fn_readback[0] == 1'b0)
    else $error("unused readback bits not zero");
  c_fn_cmd: cover property (fn_cmd);
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Purpose: self-checking bench for host controller and converter logic
// Assumes: host answers with zero wait states, link latencies per hand-over
// Notes: gp pins resolved here from the converter's enable
`timescale 1ns/1ps
`default_nettype none
`include "qdac_cfg.svh"
module tb;
  import qdac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic supply_stable, fault_n, ext0, ext1, pin0, pin1, out0, oe0, out1, oe1;
  logic gnd_en, det_out, err;
  code_t [3:0] code;
  range_t [3:0] rng;
  trim_t [3:0] trim;
  span_e [3:0] span;
  adj_t [3:0] padj, nadj;
  logic [3:0] amp, clamp;
  code_t exp_code [4];
  int error_cnt, tests_run, cyc, i, j;
  // the far driver backs off when the converter drives, as on a real shared pin
  assign pin0 = oe0 ? out0 : ext0;
  assign pin1 = oe1 ? out1 : ext1;
  qdac_link_if link ();
  qdac_host u_qdac_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  qdac_device u_qdac_device (.pclk(pclk), .presetn(presetn), .link(link),
    .supply_stable(supply_stable), .supply_fault_input_n(fault_n), .gp_pin_zero_in(pin0),
    .gp_pin_one_in(pin1), .gp_pin_zero_out(out0), .gp_pin_zero_oe(oe0),
    .gp_pin_one_out(out1), .gp_pin_one_oe(oe1), .channel_output_code(code),
    .channel_range_select(rng), .channel_gain_trim(trim), .channel_span(span),
    .pos_endpoint_adj(padj), .neg_endpoint_adj(nadj), .amp_connect_gate(amp),
    .output_clamp_gate(clamp), .local_gnd_adjust_en(gnd_en), .supply_detect_output(det_out));
  qdac_monitor u_qdac_monitor (.pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
    .register_select_field(link.register_select_field),
    .channel_select_field(link.channel_select_field), .cmd_data(link.cmd_data),
    .fn_readback(link.fn_readback), .supply_detect(link.supply_detect));
  // ==========================================================
  // clock and timeout
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run;
    end
  end
  // ==========================================================
  // tasks
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; entered just after an edge, leaves one idle edge after it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait count assumed; only the bench timeout ends a stuck transfer
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_val(rdat, exp);
  endtask
  // settings and derived span/adjust are settled once this returns
  task wcmd(input logic [2:0] r, input logic [2:0] c, input logic [15:0] d);
    apb(1'b1, `QDAC_OFS_CMD, {10'h000, r, c, d});
    repeat (3) @(posedge pclk);
  endtask
  task check_codes;
    for (j = 0; j < 4; j++) check_val(code[j], exp_code[j]);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supply_stable = 1'b1;
    fault_n = 1'b1;
    ext0 = 1'b0;
    ext1 = 1'b0;
    for (i = 0; i < 4; i++) exp_code[i] = 14'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    for (i = 0; i < 4; i++) begin
      check_val(rng[i], 32'h0);
      check_val(trim[i], 32'h0);
    end
    check_val({amp, clamp}, 32'h0f);
    rd(`QDAC_OFS_STATUS, 32'h0001_0000);
    for (i = 0; i < 4; i++) begin
      exp_code[i] = 14'h2001 + 14'h0111 * i;
      wcmd(REG_CODE, i, {exp_code[i], 2'(i + 1)});
      check_codes;
    end
    repeat (2) @(posedge pclk);
    check_val({amp, clamp}, 32'hf0);
    wcmd(REG_CODE, 3'h5, 16'hffff);
    check_codes;
    fault_n <= 1'b0;
    repeat (6) @(posedge pclk);
    check_val({amp, clamp}, 32'h0f);
    fault_n <= 1'b1;
    wcmd(REG_RANGE, `QDAC_CHAN_ALL, 16'hfffe);
    for (i = 0; i < 4; i++) check_val({rng[i], span[i]}, 32'ha);
    check_codes;
    // code 11 on the last channel is kept and flagged as an invalid span
    for (i = 0; i < 4; i++) begin
      wcmd(REG_RANGE, i, 16'(i));
      check_val(span[i], i);
    end
    wcmd(REG_TRIM, 3'h0, 16'hffe0);
    wcmd(REG_TRIM, 3'h1, 16'h001f);
    check_val({trim[0], padj[0], nadj[0]}, {12'h0, 6'h20, 7'h60, 7'h20});
    check_val({trim[1], padj[1], nadj[1]}, {12'h0, 6'h1f, 7'h1f, 7'h61});
    check_val({rng[0], rng[1]}, 32'h1);
    wcmd(REG_TRIM, `QDAC_CHAN_ALL, 16'hffc0);
    for (i = 0; i < 4; i++) check_val({padj[i], nadj[i]}, 32'h0);
    ext0 <= 1'b1;
    wcmd(REG_FUNCTION, `QDAC_FN_IO_ADDR, 16'h003a);
    check_val({oe1, out1, oe0, out0, gnd_en}, 32'h19);
    rd(`QDAC_OFS_STATUS, 32'h0001_003a);
    ext0 <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`QDAC_OFS_STATUS, 32'h0001_0038);
    wcmd(REG_FUNCTION, `QDAC_FN_IO_ADDR, 16'h001e);
    check_val({oe1, out1, oe0, out0, gnd_en}, 32'h1e);
    rd(`QDAC_OFS_STATUS, 32'h0001_001e);
    wcmd(REG_FUNCTION, `QDAC_FN_IO_ADDR, 16'h0000);
    check_val({oe1, oe0, gnd_en}, 32'h0);
    supply_stable <= 1'b0;
    repeat (6) @(posedge pclk);
    check_val({det_out, amp, clamp}, 32'h00f);
    rd(`QDAC_OFS_STATUS, 32'h0);
    supply_stable <= 1'b1;
    repeat (6) @(posedge pclk);
    check_val({det_out, amp, clamp}, 32'h10f);
    for (i = 0; i < 4; i++) exp_code[i] = 14'h1000;
    wcmd(REG_CODE, `QDAC_CHAN_ALL, 16'h4000);
    check_codes;
    repeat (2) @(posedge pclk);
    check_val({amp, clamp}, 32'hf0);
    apb(1'b0, 12'h008, 32'h0);
    check_val(err, 32'h1);
    complete_run;
  end
endmodule
`default_nettype wire
